// File: rtl/eerd_read_path.sv
`timescale 1ns/100ps
`include "eerd_defines.svh"

// How it works
// [RQ1] Matching select byte with read direction is acked, reads at pointer
// [RQ2] After read ack, current byte shifts out, then line released for ack
// [RQ3] Not-acknowledge then STOP ends sending and returns to standby
// [RQ4] Master sends dummy write: START, write select, word address only
// [RQ5] After word address ack, master repeats START with read select
// [RQ6] Read after dummy write returns byte at the loaded word address
// [RQ7] Master ends single random read with not-acknowledge and STOP
// [RQ8] Each master acknowledge makes the next location go out
// [RQ9] Sequential reads step the full pointer, wrapping at array end
// [RQ10] Select byte: fixed one, three select bits, three upper bits, R/W
// [RQ11] Middle select bit matches inverted pin, others match pins directly
// [RQ12] Sample on rising clock, change on falling, drive open-drain
// [RQ13] Data line released in ninth clock of each sent byte
// [RQ14] Pointer kept across transactions, one past last byte read
// [RQ15] Eleven-bit pointer wraps from 7FF to 000
module eerd_read_path
  import eerd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [2:0] device_select_pins,
  input wire logic fill_en,
  input wire logic [`EERD_ADDR_W-1:0] fill_addr,
  input wire logic [`EERD_DATA_W-1:0] fill_data,
  output logic bus_busy
);

  function automatic logic [`EERD_ADDR_W-1:0] ptr_inc(
    input logic [`EERD_ADDR_W-1:0] p
  );
    ptr_inc = p + `EERD_PTR_ONE; // RQ15
  endfunction

  logic [`EERD_SYNC_W-1:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic [2:0] pins_l;
  logic sda_d_r;
  logic scl_d_r;
  logic start_r;
  logic stop_r;
  logic busy_r;
  logic drv_zero_r;
  logic start_det;
  logic stop_det;
  logic link_rst_n;

  logic [`EERD_DATA_W-1:0] mem [0:(1<<`EERD_ADDR_W)-1];

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [6:0] shreg_r;
  eerd_state_e state_r;
  eerd_state_e state_nxt;
  eerd_state_e pend_r;
  eerd_state_e pend_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [`EERD_ADDR_W-1:0] ptr_r;
  logic [`EERD_ADDR_W-1:0] ptr_nxt;
  logic oe_n_r;
  logic oe_n_nxt;

  logic [`EERD_DATA_W-1:0] byte_in;
  logic sel_match;
  logic is_read;
  logic at_last;
  logic at_ack;
  logic in_tx;
  logic tx_bit;
  logic drive_low;
  logic sel_fixed_ok;
  logic [2:0] sel_dev_want;
  logic sel_dev_ok;
  logic addr_last;
  logic waddr_last;
  logic tx_ack;
  logic load_upper;
  logic load_lower;
  logic [`EERD_DATA_W-1:0] tx_byte_r;
  logic [`EERD_DATA_W-1:0] tx_byte_nxt;

  // System clock side: condition detection and fill port

  eerd_sync #(.W(`EERD_SYNC_W)) u_sync
  (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({scl_clk, sda_in}),
    .q(sync_q)
  );

  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  // Straps resampled on the link clock, the domain that compares them
  eerd_sync #(.W(3)) u_pin_sync
  (
    .clk(scl_clk),
    .rst_n(rst_n),
    .d(device_select_pins),
    .q(pins_l)
  );

  // Clock must be seen high twice; blocks a false edge out of reset
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b0;
    end
    else
    begin
      sda_d_r <= sda_s;
      scl_d_r <= scl_s;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end
    else
    begin
      start_r <= start_det;
      stop_r <= stop_det; // RQ3
    end
  end

  // START wins over a STOP seen in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_r <= 1'b0;
    else
      busy_r <= start_r | (busy_r & ~stop_r);
  end

  // Open drain: the pad only ever pulls low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      drv_zero_r <= 1'b0;
    else
      drv_zero_r <= 1'b0; // RQ12
  end

  assign bus_busy = busy_r;
  assign sda_out = drv_zero_r;

  // Backdoor fill; contents must stay still while a read is in flight
  always_ff @(posedge sys_clk)
  begin
    if (fill_en)
      mem[fill_addr] <= fill_data;
  end

  // Flop-driven pulse; recovers long before the next link clock edge
  assign link_rst_n = rst_n & ~start_r & ~stop_r; // RQ3

  // Link side: rising edge samples, falling edge drives

  assign byte_in = {shreg_r, sda_in};
  assign sel_fixed_ok =
    byte_in[`EERD_SEL_FIXED_POS] == `EERD_SEL_FIXED_VAL; // RQ10
  assign sel_dev_want = {pins_l[2], ~pins_l[1], pins_l[0]}; // RQ11
  assign sel_dev_ok =
    byte_in[`EERD_SEL_DEV_HI:`EERD_SEL_DEV_LO] == sel_dev_want; // RQ10
  assign sel_match = sel_fixed_ok & sel_dev_ok;
  assign is_read = byte_in[`EERD_SEL_RW_POS] == `EERD_RW_READ; // RQ1
  assign at_last = cnt_r == `EERD_CNT_LAST;
  assign at_ack = cnt_r == `EERD_CNT_ACK;
  assign in_tx = state_r == ST_TX;
  assign addr_last = at_last & (state_r == ST_ADDR);
  assign waddr_last = at_last & (state_r == ST_WADDR);
  assign tx_ack = at_ack & in_tx;
  assign load_upper = addr_last & sel_match & ~is_read; // RQ10
  assign load_lower = waddr_last; // RQ6
  assign cnt_nxt = at_ack ? `EERD_CNT_ZERO : cnt_r + `EERD_CNT_ONE;

  always_comb
  begin
    case (state_r)
      ST_ADDR:
        pend_nxt = !sel_match ? ST_IDLE : (is_read ? ST_TX : ST_WADDR); // RQ1
      ST_WADDR:
        pend_nxt = ST_WDATA;
      ST_TX:
        pend_nxt = ST_TX;
      default:
        pend_nxt = ST_IDLE;
    endcase
  end

  assign ack_nxt = at_ack ? 1'b0
    : at_last ? ((addr_last & sel_match) | waddr_last)
    : ack_r; // RQ1

  // Master ack keeps sending; not-ack drops out until the next START or STOP
  assign state_nxt = !at_ack ? state_r
    : in_tx ? (sda_in ? ST_IDLE : ST_TX) // RQ8 RQ3
    : pend_r;

  always_comb
  begin
    ptr_nxt = ptr_r;
    if (load_upper)
      ptr_nxt[`EERD_PTR_UPPER_HI:`EERD_PTR_UPPER_LO] =
        byte_in[`EERD_SEL_UPPER_HI:`EERD_SEL_UPPER_LO]; // RQ10
    else if (load_lower)
      ptr_nxt[`EERD_PTR_LOWER_HI:0] = byte_in; // RQ6
    else if (tx_ack)
      ptr_nxt = ptr_inc(ptr_r); // RQ9 RQ14
  end

  always_ff @(posedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      cnt_r <= `EERD_CNT_ZERO;
      shreg_r <= 7'h00;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      shreg_r <= byte_in[6:0]; // RQ12
    end
  end

  always_ff @(posedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      state_r <= ST_ADDR;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      pend_r <= ST_IDLE;
      ack_r <= 1'b0;
    end
    else
    begin
      pend_r <= at_last ? pend_nxt : pend_r;
      ack_r <= ack_nxt;
    end
  end

  // Byte latched at the ack clock, so the array is read once per byte
  assign tx_byte_nxt = at_ack ? mem[ptr_nxt] : tx_byte_r; // RQ8

  always_ff @(posedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      tx_byte_r <= 8'h00;
    else
      tx_byte_r <= tx_byte_nxt; // RQ2
  end

  // Pointer survives START and STOP; only power-on clears it
  always_ff @(posedge scl_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_r <= `EERD_PTR_RST;
    else
      ptr_r <= ptr_nxt; // RQ14
  end

  // Array written on the system clock; quasi-static here by contract
  assign tx_bit = tx_byte_r[~cnt_r[2:0]]; // RQ2
  assign drive_low = at_ack ? ack_r : (in_tx & ~tx_bit); // RQ13
  assign oe_n_nxt = ~drive_low;

  always_ff @(negedge scl_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      oe_n_r <= 1'b1;
    else
      oe_n_r <= oe_n_nxt; // RQ12
  end

  assign sda_oe_n = oe_n_r;

endmodule // eerd_read_path

// File: rtl/eerd_defines.svh
`ifndef EERD_DEFINES_SVH
`define EERD_DEFINES_SVH

// Memory geometry
`define EERD_ADDR_W 11
`define EERD_DATA_W 8
`define EERD_PTR_RST 11'h000
`define EERD_PTR_ONE 11'h001

// Select byte layout
`define EERD_SEL_FIXED_POS 7
`define EERD_SEL_FIXED_VAL 1'b1
`define EERD_SEL_DEV_HI 6
`define EERD_SEL_DEV_LO 4
`define EERD_SEL_UPPER_HI 3
`define EERD_SEL_UPPER_LO 1
`define EERD_SEL_RW_POS 0
`define EERD_RW_READ 1'b1
`define EERD_PTR_UPPER_HI 10
`define EERD_PTR_UPPER_LO 8
`define EERD_PTR_LOWER_HI 7

// Bit counter marks within one nine-clock byte slot
`define EERD_CNT_ZERO 4'h0
`define EERD_CNT_ONE 4'h1
`define EERD_CNT_LAST 4'h7
`define EERD_CNT_ACK 4'h8

// Synchroniser width: clock sample, data sample
`define EERD_SYNC_W 2

`endif

// File: rtl/eerd_pkg.sv
package eerd_pkg;

  typedef enum logic [4:0]
  {
    ST_ADDR  = 5'h01,
    ST_WADDR = 5'h02,
    ST_WDATA = 5'h04,
    ST_TX    = 5'h08,
    ST_IDLE  = 5'h10
  } eerd_state_e;

endpackage

// File: rtl/eerd_sync.sv
`timescale 1ns/100ps

module eerd_sync
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // eerd_sync

// File: tb/eerd_read_path_assertions.sv
`timescale 1ns/100ps
module eerd_chk
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic bus_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_drive_zero: assert property (sda_out == 1'b0)
    else $error("drive value not 0");
  chk_idle_float: assert property (!bus_busy |-> sda_oe_n)
    else $error("line pulled in standby");
  chk_pull_low: assert property ($fell(sda_oe_n) |-> !scl_clk)
    else $error("pull began with clock high");
  chk_bit_hold: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*5])
    else $error("driven bit too short");
  chk_high_stable: assert property (scl_clk && $past(scl_clk)
    |-> $stable(sda_oe_n)) else $error("line moved with clock high");
  chk_start_busy: assert property ($fell(sda_in) && scl_clk
    && $past(scl_clk) |-> ##[1:8] bus_busy) else $error("start missed");
  chk_stop_idle: assert property ($rose(sda_in) && scl_clk
    && $past(scl_clk) |-> ##[1:8] !bus_busy) else $error("stop missed");
  chk_reset_idle: assert property ($rose(rst_n)
    |-> sda_oe_n && !bus_busy) else $error("not idle after reset");
  cover property ($rose(bus_busy));
  cover property ($fell(sda_oe_n));
  cover property (@(negedge scl_clk) !sda_oe_n [*8]);
endmodule // eerd_chk
bind eerd_read_path eerd_chk i_chk (.sys_clk, .rst_n, .scl_clk, .sda_in,
  .sda_out, .sda_oe_n, .bus_busy);

// File: tb/eerd_master.sv
`timescale 1ns/100ps
module eerd_master
(
  output logic scl_clk,
  output logic sda_drv_n,
  input wire logic sda_in
);
  // Clock parks high between frames
  initial
  begin
    scl_clk = 1'b1;
    sda_drv_n = 1'b1;
  end
  task automatic bit_io(input logic v, output logic s);
    #8 sda_drv_n = v;
    #8 scl_clk = 1'b1;
    s = sda_in;
    #16 scl_clk = 1'b0;
  endtask
  task automatic start();
    #8 sda_drv_n = 1'b1;
    #8 scl_clk = 1'b1;
    #28 sda_drv_n = 1'b0;
    #28 scl_clk = 1'b0;
  endtask
  task automatic stop();
    #8 sda_drv_n = 1'b0;
    #8 scl_clk = 1'b1;
    #28 sda_drv_n = 1'b1;
    #28;
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], ack);
    bit_io(1'b1, ack);
  endtask
  task automatic rx(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule // eerd_master

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  logic fill_en = 1'b0;
  logic [10:0] fill_addr = 11'h000;
  logic [7:0] fill_data = 8'h00;
  logic [2:0] device_select_pins = 3'h0;
  logic scl_clk, sda_drv_n, sda_out, sda_oe_n, bus_busy, ack;
  wire sda_in = sda_drv_n & (sda_oe_n | sda_out);
  logic [7:0] mem [2048];
  logic [10:0] ptr = 11'h000;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  eerd_read_path i_dut (.sys_clk, .rst_n, .scl_clk, .sda_in, .sda_out,
    .sda_oe_n, .device_select_pins, .fill_en, .fill_addr, .fill_data,
    .bus_busy);
  eerd_master i_mst (.scl_clk, .sda_drv_n, .sda_in);
  function automatic logic [7:0] sel(input logic rw, input logic [2:0] u);
    return {1'b1, device_select_pins[2], ~device_select_pins[1],
      device_select_pins[0], u, rw};
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic rd(input logic rnd, input logic [10:0] a, input int n);
    logic [7:0] d;
    i_mst.start();
    if (rnd)
    begin
      i_mst.tx(sel(1'b0, a[10:8]), ack);
      check(ack, 1'b0);
      i_mst.tx(a[7:0], ack);
      check(ack, 1'b0);
      i_mst.start();
      ptr = a;
    end
    i_mst.tx(sel(1'b1, 3'h0), ack);
    check(ack, 1'b0);
    check(bus_busy, 1'b1);
    for (int i = 1; i <= n; i++)
    begin
      i_mst.rx(i == n, d);
      check(d, mem[ptr]);
      ptr = ptr + 11'h001;
    end
    i_mst.stop();
    repeat (4) @(posedge sys_clk);
    check(bus_busy, 1'b0);
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    void'($urandom(32'hc0c6_043e));
    device_select_pins = 3'($urandom);
    // A real falling edge, so every asynchronous reset branch runs
    #1 rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1.3 rst_n = 1'b1;
    for (int a = 0; a < 2048; a++)
    begin
      mem[a] = 8'($urandom);
      fill_en = 1'b1;
      fill_addr = 11'(a);
      fill_data = mem[a];
      @(posedge sys_clk);
      #1.3;
    end
    fill_en = 1'b0;
    rd(1'b0, 11'h000, 2);
    rd(1'b1, 11'h7fe, 4);
    rd(1'b0, 11'h000, 1);
    repeat (4) rd(1'b1, 11'($urandom), 3);
    // Middle select bit not inverted must be ignored
    i_mst.start();
    i_mst.tx(sel(1'b1, 3'h0) ^ 8'h20, ack);
    check(ack, 1'b1);
    i_mst.stop();
    summarize();
  end
endmodule // testbench
